/* include/rplg_params.svh */
// Constants for the ring port loop guard: frame fields, addresses, timings.
// Assumes a 40 MHz node clock; included by rplg_port_fsm, rplg_top and the bench.
`ifndef RPLG_PARAMS_SVH
`define RPLG_PARAMS_SVH

// Clock rate in kHz, used to turn milliseconds into cycles
`define RPLG_CLK_KHZ        40000
// Default preforwarding time in milliseconds
`define RPLG_PREFWD_MS      300
// Default dead time in milliseconds
`define RPLG_DEAD_MS        300
// Default hello interval in milliseconds
`define RPLG_HELLO_MS       100
// Frame word layout: [31:24] ring id, [23] forwarding bit, [15:0] sequence
`define RPLG_F_ID_LSB       24
`define RPLG_F_FWD_BIT      23
`define RPLG_F_SEQ_LSB      0
// Reset value of the sequence counter
`define RPLG_SEQ_RST        16'h0000
// Highest legal ring identifier
`define RPLG_ID_MAX         8'hff
// Reserved protocol destination address; value is arbitrary
`define RPLG_PROTO_DA       48'h0000_0000_0001

`endif

/* include/rplg_pkg.sv */
// Types shared by the ring port loop guard modules.
// Assumes rplg_params.svh is on the include path.
package rplg_pkg;
	// Per-interface ring state, one-hot
	typedef enum logic [2:0] {
		RPLG_PREFWD = 3'b001,
		RPLG_FWD    = 3'b010,
		RPLG_BLOCK  = 3'b100
	} rplg_state_t;
endpackage

/* include/rplg_port_if.sv */
// Interface bundling one ring interface's controls between top and port.
// Assumes both ends share the node clock.
`timescale 1ns/10ps
interface rplg_port_if;
	import rplg_pkg::*;
	logic        enable;     // Ring function enabled
	logic        is_sec;     // Master secondary interface
	logic [7:0]  ring_id;    // Own ring identifier
	logic        rx_valid;   // Health frame received
	logic        rx_fwd;     // Received frame forwarding bit
	logic        rx_own;     // Frame came from own primary
	logic        link_up;    // Link present
	rplg_state_t state;      // Current state
	modport ctl  (output enable, is_sec, ring_id, rx_valid, rx_fwd, rx_own,
		link_up, input state);
	modport port (input enable, is_sec, ring_id, rx_valid, rx_fwd, rx_own,
		link_up, output state);
endinterface // rplg_port_if

/* hw/rplg_port_fsm.sv */
// State machine for one ring interface: preforwarding, forwarding, block.
// Assumes frame strobes are already synchronised to clk.
`timescale 1ns/10ps
`include "rplg_params.svh"
module rplg_port_fsm
	import rplg_pkg::*;
#(
	parameter int PREFWD_CYC = 1000,
	parameter int DEAD_CYC   = 1000
) (
	input  wire logic clk,
	input  wire logic reset_n,
	rplg_port_if.port pif
);
	// Elaboration guard: a timer needs at least one cycle
	if (PREFWD_CYC < 1 || DEAD_CYC < 1) begin : g_bad_cyc
		$error("rplg_port_fsm: timer counts must be positive");
	end

	rplg_state_t state_reg;        // Current state
	logic [31:0] timer_reg;        // Preforwarding or dead timer
	logic        en_d_reg;         // Enable seen last cycle
	logic        link_d_reg;       // Link seen last cycle

	// Start or link repair put the interface back in preforwarding
	wire start = (pif.enable & ~en_d_reg) | (pif.link_up & ~link_d_reg);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_d_reg   <= 1'b0;
			link_d_reg <= 1'b0;
		end else begin
			en_d_reg   <= pif.enable;
			link_d_reg <= pif.link_up;
		end
	end

	// State and timer together; the timer means dead time in blocking
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= RPLG_PREFWD;
			timer_reg <= 32'h0;
		end else if (!pif.enable || start) begin
			state_reg <= RPLG_PREFWD;
			timer_reg <= 32'(PREFWD_CYC);
		end else begin
			case (state_reg)
				RPLG_PREFWD: begin
					if (pif.is_sec && pif.rx_valid && pif.rx_own) begin
						// Own frame back: ring intact
						state_reg <= RPLG_BLOCK;
						timer_reg <= 32'(DEAD_CYC);
					end else if (!pif.is_sec && pif.rx_valid && pif.rx_fwd) begin
						state_reg <= RPLG_FWD;
					end else if (timer_reg <= 32'h1) begin
						state_reg <= RPLG_FWD;
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				RPLG_BLOCK: begin
					if (pif.rx_valid && pif.rx_own) begin
						timer_reg <= 32'(DEAD_CYC);
					end else if (timer_reg <= 32'h1) begin
						state_reg <= RPLG_PREFWD;
						timer_reg <= 32'(PREFWD_CYC);
					end else begin
						timer_reg <= timer_reg - 32'h1;
					end
				end
				RPLG_FWD: begin
					// Secondary returns to blocking when own frame returns
					if (pif.is_sec && pif.rx_valid && pif.rx_own) begin
						state_reg <= RPLG_BLOCK;
						timer_reg <= 32'(DEAD_CYC);
					end
				end
				default: state_reg <= RPLG_PREFWD;
			endcase
		end
	end

	assign pif.state = state_reg;
endmodule // rplg_port_fsm

/* hw/rplg_top.sv */
// Ring loop guard for one node: two ring interfaces per ring, NR rings.
// Assumes frame receive strobes come from the node clock domain; the link
// status bits are pins and are synchronised here.
//
// Behaviour
// - Each ring handled independently, own frames only
// - Lower ring identifier means higher priority
// - Shared interface takes lowest sharing identifier; code takes lowest of own id and every enabled ring's id
// - Top-priority ring ports regular, others tunnel
// - Enable starts every interface in preforwarding
// - Master sends frames with own source address
// - Preforwarding passes health frames, drops data
// - Preforwarding timer expiry moves to forwarding
// - Only master secondary may block
// - Primary sends frame at once on enable
// - Returned frame blocks; forwarding bit frame follows
// - No return before timeout means forwarding
// - Each frame carries a sequence number
// - Regular ports relay, master secondary terminates
// - Tunnel port forwards frames of equal priority
// - Shared port forwards lower-priority frames across
// - Lower frames also flood the higher ring
// - Dead timer expiry returns block to preforwarding
// - Preforwarding secondary ignores other rings' frames
// - Repaired link interfaces restart in preforwarding
`timescale 1ns/10ps
`include "rplg_params.svh"
module rplg_top
	import rplg_pkg::*;
#(
	parameter int NR         = 2,      // Rings handled by this node
	parameter int PREFWD_MS  = `RPLG_PREFWD_MS,
	parameter int DEAD_MS    = `RPLG_DEAD_MS,
	parameter int HELLO_MS   = `RPLG_HELLO_MS,
	parameter int PREFWD_CYC = PREFWD_MS * `RPLG_CLK_KHZ,
	parameter int DEAD_CYC   = DEAD_MS * `RPLG_CLK_KHZ,
	parameter int HELLO_CYC  = HELLO_MS * `RPLG_CLK_KHZ
) (
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic [NR-1:0]   ring_enable,
	input  wire logic [NR-1:0]   ring_master,
	input  wire logic [NR*8-1:0] ring_id,
	input  wire logic [NR-1:0]   pri_shared,
	input  wire logic [NR-1:0]   sec_shared,
	input  wire logic [47:0]     node_mac,
	input  wire logic [2*NR-1:0] link_up,
	input  wire logic [2*NR-1:0] rx_valid,
	input  wire logic [31:0]     rx_word,
	input  wire logic [2*NR-1:0] rx_data,
	output logic      [2*NR-1:0] port_state_fwd,
	output logic      [2*NR-1:0] port_state_blk,
	output logic      [2*NR-1:0] data_pass,
	output logic      [2*NR-1:0] frame_relay,
	output logic      [2*NR-1:0] port_tunnel,
	output logic      [2*NR*8-1:0] port_prio,
	output logic      [NR-1:0]   master_ok,
	output logic                 tx_valid,
	output logic      [NR-1:0]   tx_ring,
	output logic      [47:0]     tx_src_mac,
	output logic      [47:0]     tx_dst_mac,
	output logic      [31:0]     tx_word,
	output logic      [NR*16-1:0] rtt_cycles
);
	// Reserved protocol destination; value is arbitrary
	localparam logic [47:0] PROTO_DA = `RPLG_PROTO_DA;

	// Elaboration guard: ring count and hello count must be servable
	if (NR < 1 || NR > 8) begin : g_bad_nr
		$error("rplg_top: NR must be 1..8");
	end
	if (HELLO_CYC < 1) begin : g_bad_hello
		$error("rplg_top: hello count must be positive");
	end

	logic [2*NR-1:0] link_s1_reg;   // Pin synchroniser, first stage
	logic [2*NR-1:0] link_s2_reg;   // Pin synchroniser, second stage

	// Link status arrives from the PHY side; two flops before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link_s1_reg <= '0;
			link_s2_reg <= '0;
		end else begin
			link_s1_reg <= link_up;
			link_s2_reg <= link_s1_reg;
		end
	end

	// Decoded fields of the received frame word
	wire [7:0] rx_id  = rx_word[`RPLG_F_ID_LSB +: 8];
	wire       rx_fwd = rx_word[`RPLG_F_FWD_BIT];

	// Lowest identifier among the node's enabled rings
	logic [7:0] best_id;
	always_comb begin
		best_id = `RPLG_ID_MAX;
		for (int r = 0; r < NR; r++) begin
			if (ring_enable[r] && ring_id[r*8 +: 8] < best_id)
				best_id = ring_id[r*8 +: 8];
		end
	end

	// Shared interface priority: lowest of own id and every enabled ring's id
	// Values come in as arguments, so a continuous assign sees each change
	function automatic logic [7:0] share_prio(input logic [7:0] own_id,
		input logic [NR*8-1:0] ids, input logic [NR-1:0] en);
		logic [7:0] p;
		p = own_id;
		for (int q = 0; q < NR; q++) begin
			if (en[q] && ids[q*8 +: 8] < p)
				p = ids[q*8 +: 8];
		end
		return p;
	endfunction

	logic [NR*16-1:0] seq_reg;      // Sequence number per ring
	logic [NR*16-1:0] sent_reg;     // Sequence of last sent frame
	logic [NR*16-1:0] rtt_reg;      // Round-trip counter per ring
	logic [NR-1:0]    fwdbit_reg;   // Next frame carries forwarding bit
	logic [NR*32-1:0] hello_reg;    // Hello interval counter
	logic [NR-1:0]    en_d_reg;     // Enable seen last cycle
	logic [NR-1:0]    pend_reg;     // Frame waiting for transmit slot
	logic [31:0]      tx_word_reg;  // Transmitted frame word
	logic [NR-1:0]    tx_ring_reg;  // Ring of the transmitted frame
	logic             tx_valid_reg; // Transmit strobe
	rplg_state_t      st [2*NR];    // State of each interface

	genvar g;
	generate
		for (g = 0; g < 2*NR; g++) begin : g_port
			localparam int R = g / 2;
			localparam bit SEC = (g % 2) == 1;
			rplg_port_if pif ();
			// Own-origin frame: same ring id, last sent sequence and master on this ring
			wire own = ring_master[R] && rx_id == ring_id[R*8 +: 8]
				&& rx_word[`RPLG_F_SEQ_LSB +: 16] == sent_reg[R*16 +: 16];
			wire [7:0] my_prio = (SEC ? sec_shared[R] : pri_shared[R])
				? share_prio(ring_id[R*8 +: 8], ring_id, ring_enable)
				: ring_id[R*8 +: 8];
			// A shared port of top priority stays regular
			wire tunnel = my_prio != best_id;
			assign pif.enable   = ring_enable[R];
			assign pif.is_sec   = SEC && ring_master[R];
			assign pif.ring_id  = ring_id[R*8 +: 8];
			// Only own ring's frames reach this ring's machine
			assign pif.rx_valid = rx_valid[g]
				&& rx_id == ring_id[R*8 +: 8];
			assign pif.rx_fwd   = rx_fwd;
			assign pif.rx_own   = own;
			assign pif.link_up  = link_s2_reg[g];
			rplg_port_fsm #(
				.PREFWD_CYC (PREFWD_CYC),
				.DEAD_CYC   (DEAD_CYC)
			) u_fsm (
				.clk     (clk),
				.reset_n (reset_n),
				.pif     (pif)
			);
			assign st[g] = pif.state;
			assign port_prio[g*8 +: 8] = my_prio;
			assign port_tunnel[g] = tunnel;

			// Frame relay decision, registered
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					frame_relay[g] <= 1'b0;
				else if (!rx_valid[g] || !ring_enable[R])
					frame_relay[g] <= 1'b0;
				else if (pif.is_sec && st[g] == RPLG_BLOCK
					&& rx_id >= my_prio)
					frame_relay[g] <= 1'b0;
				else if (pif.is_sec && rx_id == pif.ring_id)
					frame_relay[g] <= 1'b0;
				else if (tunnel)
					frame_relay[g] <= rx_id == my_prio;
				else
					// Regular: own ring or lower-priority frame floods on
					frame_relay[g] <= rx_id >= my_prio;
			end

			// Data forwarding only in forwarding state
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					data_pass[g]      <= 1'b0;
					port_state_fwd[g] <= 1'b0;
					port_state_blk[g] <= 1'b0;
				end else begin
					data_pass[g] <= rx_data[g] && st[g] == RPLG_FWD
						&& ring_enable[R];
					port_state_fwd[g] <= st[g] == RPLG_FWD;
					port_state_blk[g] <= st[g] == RPLG_BLOCK;
				end
			end
		end
	endgenerate

	// Master eligibility: no shared links, or ring id is the lowest enabled id
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			master_ok <= '0;
		else
			for (int r = 0; r < NR; r++)
				master_ok[r] <= !(pri_shared[r] || sec_shared[r])
					|| ring_id[r*8 +: 8] == best_id;
	end

	// Per-ring frame generation and round-trip timing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			seq_reg    <= '0;
			sent_reg   <= '0;
			rtt_reg    <= '0;
			rtt_cycles <= '0;
			fwdbit_reg <= '0;
			hello_reg  <= '0;
			en_d_reg   <= '0;
			pend_reg   <= '0;
		end else begin
			en_d_reg <= ring_enable;
			for (int r = 0; r < NR; r++) begin
				if (!ring_enable[r] || !ring_master[r]) begin
					pend_reg[r]        <= 1'b0;
					fwdbit_reg[r]      <= 1'b0;
					hello_reg[r*32 +: 32] <= 32'h0;
				end else begin
					rtt_reg[r*16 +: 16] <= rtt_reg[r*16 +: 16] + 16'h1;
					// Grant clears first, so a request raised now survives
					if (pend_reg[r] && tx_ring_reg == '0
						&& grant(r)) begin
						pend_reg[r] <= 1'b0;
						seq_reg[r*16 +: 16] <= seq_reg[r*16 +: 16] + 16'h1;
						sent_reg[r*16 +: 16] <= seq_reg[r*16 +: 16];
						rtt_reg[r*16 +: 16] <= 16'h0;
					end
					if (!en_d_reg[r]) begin
						pend_reg[r] <= 1'b1;
						hello_reg[r*32 +: 32] <= 32'(HELLO_CYC);
					end else if (rx_valid[2*r+1] && g_port_own(r)) begin
						// Own frame back: next frame says forward
						fwdbit_reg[r] <= 1'b1;
						pend_reg[r]   <= 1'b1;
						rtt_cycles[r*16 +: 16] <= rtt_reg[r*16 +: 16];
					end else if (hello_reg[r*32 +: 32] <= 32'h1) begin
						pend_reg[r] <= 1'b1;
						hello_reg[r*32 +: 32] <= 32'(HELLO_CYC);
						fwdbit_reg[r] <= st[2*r+1] == RPLG_BLOCK;
					end else begin
						hello_reg[r*32 +: 32] <= hello_reg[r*32 +: 32] - 32'h1;
					end
				end
			end
		end
	end

	// Own frame check for the secondary of ring r
	function automatic logic g_port_own(input int r);
		return rx_id == ring_id[r*8 +: 8]
			&& rx_word[`RPLG_F_SEQ_LSB +: 16] == sent_reg[r*16 +: 16];
	endfunction

	// Lowest pending ring wins the single transmit slot
	function automatic logic grant(input int r);
		logic ok;
		ok = 1'b1;
		for (int q = 0; q < NR; q++)
			if (q < r && pend_reg[q])
				ok = 1'b0;
		return ok;
	endfunction

	// Transmit register: one frame per cycle pair
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_valid_reg <= 1'b0;
			tx_ring_reg  <= '0;
			tx_word_reg  <= 32'h0;
		end else begin
			tx_valid_reg <= 1'b0;
			tx_ring_reg  <= '0;
			for (int r = NR-1; r >= 0; r--) begin
				if (pend_reg[r] && tx_ring_reg == '0 && grant(r)
					&& ring_enable[r] && ring_master[r]) begin
					tx_valid_reg <= 1'b1;
					tx_ring_reg  <= NR'(1) << r;
					tx_word_reg  <= {ring_id[r*8 +: 8], fwdbit_reg[r],
						7'h00, seq_reg[r*16 +: 16]};
				end
			end
		end
	end

	assign tx_valid   = tx_valid_reg;
	assign tx_ring    = tx_ring_reg;
	assign tx_word    = tx_word_reg;
	assign tx_src_mac = node_mac;
	assign tx_dst_mac = PROTO_DA;
endmodule // rplg_top

/* test/rplg_top_checker.sv */
// Checker for the ring loop guard top: port relations over time.
// Assumes one node clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module rplg_top_checker #(
	parameter int NR = 2
) (
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic [NR-1:0]     ring_enable,
	input wire logic [NR-1:0]     ring_master,
	input wire logic [NR*8-1:0]   ring_id,
	input wire logic [NR-1:0]     pri_shared,
	input wire logic [47:0]       node_mac,
	input wire logic [2*NR-1:0]   rx_valid,
	input wire logic [31:0]       rx_word,
	input wire logic [2*NR-1:0]   rx_data,
	input wire logic [2*NR-1:0]   port_state_fwd,
	input wire logic [2*NR-1:0]   port_state_blk,
	input wire logic [2*NR-1:0]   data_pass,
	input wire logic [2*NR-1:0]   frame_relay,
	input wire logic [2*NR*8-1:0] port_prio,
	input wire logic              tx_valid,
	input wire logic [NR-1:0]     tx_ring,
	input wire logic [47:0]       tx_src_mac,
	input wire logic [31:0]       tx_word
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_pass_needs_data: assert property ((data_pass & ~$past(rx_data)) == '0)
		else $error("data passed with no data frame");
	a_pass_needs_fwd: assert property ((data_pass & ~(port_state_fwd |
		$past(port_state_fwd))) == '0)
		else $error("data passed while not forwarding");
	// Even indexes are primaries, which may never block
	a_blk_sec_only: assert property ((port_state_blk & {NR{2'b01}}) == '0)
		else $error("primary interface blocking");
	a_tx_src_mac: assert property (tx_valid |-> tx_src_mac == node_mac)
		else $error("frame source is not own address");
	a_tx_ring_id: assert property (tx_valid && tx_ring[0] |->
		tx_word[31:24] == ring_id[7:0])
		else $error("frame carries wrong ring id");
	a_first_tx: assert property (ring_master[0] && $rose(ring_enable[0]) |->
		##[1:3] (tx_valid && tx_ring[0]))
		else $error("no frame sent on enable");
	a_own_term: assert property ($past(rx_valid[1] && ring_master[0] &&
		rx_word[31:24] == ring_id[7:0]) |-> !frame_relay[1])
		else $error("secondary relayed its own frame");
	a_prio_own: assert property (!pri_shared[0] |->
		port_prio[7:0] == ring_id[7:0])
		else $error("unshared port priority differs");

	// Main scenarios seen
	c_tx: cover property (tx_valid && tx_ring[0]);
	c_blk: cover property (port_state_blk[1]);
	c_pass: cover property (data_pass != '0);
endmodule // rplg_top_checker

/* test/rplg_ring_peer.sv */
// Far side of ring 0: carries each health frame round and back.
// Assumes this node masters ring 0; answer delay set by lat (1 = prompt).
`timescale 1ns/10ps
module rplg_ring_peer (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ret_en,
	input  wire logic [3:0]  lat,
	input  wire logic        tx_valid,
	input  wire logic [1:0]  tx_ring,
	input  wire logic [31:0] tx_word,
	output logic      [3:0]  rx_valid,
	output logic      [31:0] rx_word
);
	logic [31:0] held_reg; // Frame in flight
	logic [3:0]  cnt_reg;  // Cycles left until it returns

	// Members relay unchanged, so one id per ring all the way round
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg  <= '0;
			held_reg <= '0;
			rx_valid <= '0;
			rx_word  <= '0;
		end else begin
			rx_valid <= '0;
			// Released bus toggles so no stale word can be mistaken
			rx_word  <= ~rx_word;
			if (tx_valid && tx_ring[0] && ret_en) begin
				held_reg <= tx_word;
				cnt_reg  <= lat;
			end else if (cnt_reg == 4'h1) begin
				rx_valid <= 4'b0010; // Back at ring 0 secondary
				rx_word  <= held_reg;
				cnt_reg  <= '0;
			end else if (cnt_reg != '0) begin
				cnt_reg <= cnt_reg - 4'h1; // Count down; a frame already in flight still returns
			end
		end
	end
endmodule // rplg_ring_peer

/* test/rplg_top_tb.sv */
// Bench for the ring loop guard: ring 0 mastered here, ring 1 a member.
// Assumes the peer model closes ring 0; long counts shortened.
`timescale 1ns/10ps
`include "rplg_params.svh"
module rplg_top_tb;
	localparam int NR = 2;
	logic        clk, reset_n, tx_valid, ret_en, seen;
	logic [1:0]  ring_enable, ring_master, pri_shared, sec_shared, tx_ring;
	logic [1:0]  mok;                            // Master eligibility seen
	logic [15:0] ring_id;                        // Ring 1 id, ring 0 id
	logic [47:0] node_mac, src, dst;             // Own, sent source and dest
	logic [3:0]  link_up, tb_v, pv, rx_valid, rx_data, lat;
	logic [3:0]  fwd, blk, dps, rly, tun;        // Per port results
	logic [31:0] tb_w, pw, rx_word, tx_word, prio, rtt;
	logic [7:0]  a;                              // Lowest (top-priority) ring identifier
	int          n_fail, num_checks, k;
	// Bench and peer share the frame strobe bus
	assign rx_valid = tb_v | pv;
	assign rx_word  = (pv != '0) ? pw : tb_w;

	rplg_top #(.NR(NR), .PREFWD_CYC(20), .DEAD_CYC(20), .HELLO_CYC(8)) i_dut (
		.clk, .reset_n, .ring_enable, .ring_master, .ring_id, .pri_shared,
		.sec_shared, .node_mac, .link_up, .rx_valid, .rx_word, .rx_data,
		.port_state_fwd(fwd), .port_state_blk(blk), .data_pass(dps),
		.frame_relay(rly), .port_tunnel(tun), .port_prio(prio),
		.master_ok(mok), .tx_valid, .tx_ring, .tx_src_mac(src),
		.tx_dst_mac(dst), .tx_word, .rtt_cycles(rtt));
	rplg_ring_peer i_peer (.clk, .reset_n, .ret_en, .lat, .tx_valid,
		.tx_ring, .tx_word, .rx_valid(pv), .rx_word(pw));

	// Free-running node clock, 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk1(string s, logic e, logic g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic chk8(string s, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s exp %h got %h", s, e, g);
		end
	endtask
	// Expected priority: a shared port takes the lower id
	function automatic logic [7:0] min_id();
		return (ring_id[7:0] < ring_id[15:8]) ? ring_id[7:0] : ring_id[15:8];
	endfunction
	function automatic logic [7:0] exp_prio(int p);
		if ((p % 2 == 1) ? sec_shared[p/2] : pri_shared[p/2])
			return min_id();
		return ring_id[(p/2)*8 +: 8];
	endfunction
	// Master eligible: no shared link, or ring holds the top priority
	function automatic logic exp_mok(int r);
		return !(pri_shared[r] | sec_shared[r])
			|| ring_id[r*8 +: 8] == min_id();
	endfunction
	// One-cycle health frame on port p, then the word line toggles away
	task automatic send(int p, logic [31:0] w);
		@(posedge clk);
		tb_v <= 4'b0001 << p;
		tb_w <= w;
		@(posedge clk);
		tb_v <= '0;
		tb_w <= ~w;
	endtask
	task automatic wait_tx;
		k = 0;
		do @(negedge clk); while (!(tx_valid && tx_ring[0]) && ++k < 60);
		chk1("tx seen", 1'b1, tx_valid & tx_ring[0]);
	endtask
	task automatic wait_blk(logic v, int n);
		for (k = 0; k < n && blk[1] !== v; k++) @(negedge clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog: run needs well under a thousand cycles
	initial begin
		tick(3000);
		n_fail++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h2c61));
		{ring_enable, ring_master, pri_shared, sec_shared, tb_v, rx_data} = '0;
		{ring_id, node_mac, tb_w, link_up, lat} = {16'h0201, 80'h0, 8'hf1};
		{ret_en, reset_n, n_fail, num_checks} = {2'b10, 64'h0};
		tick(5);
		reset_n <= 1'b1;
		tick(1);
		// Priority and port kind for random ids, shared and not
		ring_enable <= 2'b11;
		for (int i = 0; i < 4; i++) begin
			a = 8'($urandom_range(127, 1));
			@(posedge clk);
			ring_id <= i[0] ? {a, a + 8'($urandom_range(128, 1))} : {a + 8'd9, a};
			pri_shared <= {2{i[1]}}; // Sharers sit in one VLAN
			sec_shared <= {2{i[0] & i[1]}};
			@(negedge clk);
			for (int p = 0; p < 4; p++) begin
				chk8("prio", exp_prio(p), prio[p*8 +: 8]);
				chk1("tunnel", exp_prio(p) != min_id(), tun[p]);
			end
			// Eligibility is registered: look one cycle later
			@(negedge clk);
			for (int r = 0; r < NR; r++)
				chk1("master ok", exp_mok(r), mok[r]);
		end
		$display("test prio done");
		// Second reset in mid-run, then master start-up
		@(posedge clk);
		{ring_enable, reset_n} <= '0;
		tick(2);
		reset_n <= 1'b1;
		a = 8'($urandom_range(100, 1));
		{ring_id, pri_shared, sec_shared} <= {a + 8'd7, a, 4'h0};
		ring_master <= 2'b01; // Unshared, top priority: eligible
		node_mac <= {$urandom, 16'($urandom)};
		tick(2);
		ring_enable <= 2'b11;
		wait_tx;
		chk8("tx id", a, tx_word[31:24]);
		chk1("tx fwd", 1'b0, tx_word[23]);
		chk8("tx seq", 8'h00, tx_word[7:0]);
		chk1("tx src", 1'b1, src === node_mac);
		chk1("tx dst", 1'b1, dst === `RPLG_PROTO_DA);
		chk1("member pf", 1'b0, fwd[2] | blk[2]);
		wait_blk(1'b1, 10);
		chk1("sec blk", 1'b1, blk[1]);
		@(posedge clk);
		rx_data <= 4'($urandom) | 4'b0100;
		@(posedge clk);
		rx_data <= '0;
		@(negedge clk);
		chk1("pf drop", 1'b0, dps[2]);
		send(2, {a + 8'd7, 1'b1, 7'h00, 16'h0001});
		@(negedge clk);
		seen = |rly[3:2];
		@(negedge clk);
		chk1("relay", 1'b1, seen | (|rly[3:2]));
		chk1("member fwd", 1'b1, fwd[2]);
		wait_tx;
		chk1("tx fwd set", 1'b1, tx_word[23]);
		chk1("seq moved", 1'b1, tx_word[15:0] != 16'h0000);
		tick(25);
		@(negedge clk);
		chk1("timeout fwd", 1'b1, fwd[3]);
		@(posedge clk);
		rx_data <= 4'b1000;
		@(posedge clk);
		rx_data <= '0;
		@(negedge clk);
		chk1("fwd pass", 1'b1, dps[3]);
		chk1("rtt", 1'b1, rtt[15:0] != 16'h0000);
		$display("test start done");
		// Ring broken: dead timer, foreign frame, slow repair
		@(posedge clk);
		ret_en <= 1'b0;
		wait_blk(1'b0, 80);
		chk1("dead", 1'b0, blk[1]);
		send(1, {a + 8'd7, 1'b0, 7'h00, 16'h0000});
		tick(2);
		@(negedge clk);
		chk1("other ring", 1'b0, blk[1]);
		@(posedge clk);
		{ret_en, lat} <= {1'b1, 4'h6};
		wait_blk(1'b1, 40);
		chk1("reblock", 1'b1, blk[1]);
		$display("test dead done");
		// Link loss and repair on a member port
		@(posedge clk);
		link_up <= 4'b1011;
		tick(6);
		link_up <= 4'hf;
		tick(5);
		@(negedge clk);
		chk1("link pf", 1'b0, fwd[2]);
		$display("test link done");
		end_of_test();
	end
endmodule // rplg_top_tb

bind rplg_top rplg_top_checker #(.NR(NR)) i_chk (.clk, .reset_n,
	.ring_enable, .ring_master, .ring_id, .pri_shared, .node_mac, .rx_valid,
	.rx_word, .rx_data, .port_state_fwd, .port_state_blk, .data_pass,
	.frame_relay, .port_prio, .tx_valid, .tx_ring, .tx_src_mac, .tx_word);
